// *** design/pld_register_init.sv ***
// file: top of register init, preload, signature and security support
//
// The address-and-strobe port and the placing of the registers are this design's own decisions.
`timescale 1ns/100ps
module pld_register_init
   import pld_init_pkg::*;
(
   input wire logic mclk,
   input wire logic rst,
   input wire logic [7:0] addr,
   input wire logic [15:0] wdata,
   input wire logic wr,
   input wire logic rd,
   output logic [15:0] rdata,
   input wire logic [NUM_INPUTS-1:0] in_pin_i,
   input wire logic [NUM_INPUTS-1:0] in_pin_drv,
   output logic [NUM_REGS-1:0] out_pin_o,
   output logic [NUM_REGS-1:0] out_pin_oe,
   output logic por_done
);
   // ****************************************
   // declarations
   // ****************************************
   cmd_t cmd;                                   // bundled command
   logic [CFG_W-1:0] cfg_mem [CFG_WORDS];       // array pattern words
   logic [SIG_BITS-1:0] sig_q;                  // user signature
   logic [NUM_REGS-1:0] pol_q;                  // polarity per output
   logic [NUM_REGS-1:0] oe_q;                   // enable per output
   logic secure_q;                              // security cell
   logic refused_q;                             // last read was refused
   logic [15:0] rdata_q;                        // read data register
   logic [3:0] por_cnt_q;                       // power-up timer
   por_state_t por_q;                           // power-up state
   logic por_busy;                              // reset still running
   logic [NUM_INPUTS-1:0] in_s1_q;              // sync stage one
   logic [NUM_INPUTS-1:0] in_s2_q;              // sync stage two
   logic [NUM_INPUTS-1:0] in_eff;               // inputs with pull-up
   logic [NUM_REGS-1:0] q_vec;                  // true register outputs
   logic [NUM_REGS-1:0] next_vec;               // array next state
   logic [NUM_REGS-1:0] pre_en;                 // preload strobes
   logic [NUM_REGS-1:0] pre_val;                // preload values
   logic prog_go;                               // reprogram request
   logic cfg_hit;                               // address in array space
   logic sig_hit;                               // address in signature space
   logic [NUM_INPUTS-1:0] drv_s1_q; // drive flag sync stage one
   logic [NUM_INPUTS-1:0] drv_s2_q; // drive flag sync stage two
   assign cmd = '{addr: addr, wdata: wdata, wr: wr, rd: rd};
   assign cfg_hit = (cmd.addr[7:4] == ADDR_CFG_BASE[7:4]);
   assign sig_hit = (cmd.addr[7:2] == ADDR_SIG_BASE[7:2]);
   assign prog_go = cmd.wr && (cmd.addr == ADDR_PROG) && cmd.wdata[0];
   // ****************************************
   // power-up reset sequencer
   // ****************************************
   // rst stands in for the power rising; the count bounds the clear time
   always_ff @(posedge mclk)
   begin
      if (rst)
      begin
         por_q <= ST_PORST_RUN;
         por_cnt_q <= 4'h0;
      end
      else
      begin
         case (por_q)
            ST_PORST_RUN:
            begin
               if (por_cnt_q == TPR_LAST)
               begin
                  por_q <= ST_RUN;
               end
               else
               begin
                  por_cnt_q <= por_cnt_q + 4'h1;
               end
            end
            ST_RUN:
            begin
               por_q <= ST_RUN;
            end
            default:
            begin
               por_q <= ST_PORST_RUN;
            end
         endcase
      end
   end
   // busy holds every cell low through the cell's clear branch
   assign por_busy = (por_q != ST_RUN);
   assign por_done = ~por_busy;
   // ****************************************
   // input pins
   // ****************************************
   // two flops before any logic reads the pins; levels and drive
   // flags pass the same stages, so they stay aligned with each other
   always_ff @(posedge mclk)
   begin
      if (rst)
      begin
         // idle pins read high, as the pull-up would make them
         in_s1_q <= '1;
         in_s2_q <= '1;
      end
      else
      begin
         in_s1_q <= in_pin_i;
         in_s2_q <= in_s1_q;
      end
   end
   // drive flags come from outside the clock as well
   always_ff @(posedge mclk)
   begin
      if (rst)
      begin
         // released after reset: the pull-up decides
         drv_s1_q <= '0;
         drv_s2_q <= '0;
      end
      else
      begin
         drv_s1_q <= in_pin_drv;
         drv_s2_q <= drv_s1_q;
      end
   end
   assign in_eff = (in_s2_q & drv_s2_q) | ~drv_s2_q;
   // ****************************************
   // logic array stand-in
   // ****************************************
   // small parity model: word i gives input and feedback masks
   always_comb
   begin
      next_vec = '0;
      for (int i = 0; i < NUM_REGS; i++)
      begin
         // floating pins already read as one here
         next_vec[i] = ^((in_eff & cfg_mem[i][7:0]) ^ (q_vec & cfg_mem[i][15:8]));
      end
   end
   // ****************************************
   // programming store
   // ****************************************
   // reprogram wins over an array write in the same cycle
   // a reprogram erases array, output configuration and security in one step; the signature is kept
   always_ff @(posedge mclk)
   begin
      if (rst || prog_go)
      begin
         for (int i = 0; i < CFG_WORDS; i++)
         begin
            cfg_mem[i] <= RESET_WORD;
         end
      end
      else if (cmd.wr && cfg_hit)
      begin
         cfg_mem[cmd.addr[CFG_ADDR_W-1:0]] <= cmd.wdata;
      end
   end
   // signature is separate memory, rewritten at any time
   always_ff @(posedge mclk)
   begin
      if (rst)
      begin
         sig_q <= '0;
      end
      else if (cmd.wr && sig_hit)
      begin
         sig_q[cmd.addr[SIG_ADDR_W-1:0]*16 +: 16] <= cmd.wdata;
      end
   end
   // output configuration, erased with the pattern
   always_ff @(posedge mclk)
   begin
      if (rst || prog_go)
      begin
         pol_q <= '0;
         oe_q <= '0;
      end
      else if (cmd.wr && cmd.addr == ADDR_POL)
      begin
         pol_q <= cmd.wdata[NUM_REGS-1:0];
      end
      else if (cmd.wr && cmd.addr == ADDR_OE)
      begin
         oe_q <= cmd.wdata[NUM_REGS-1:0];
      end
   end
   // security cell; reset models a blank part
   // a power cycle blanks the array too, so nothing is left to read
   always_ff @(posedge mclk)
   begin
      if (rst)
      begin
         secure_q <= 1'b0;
      end
      else if (prog_go)
      begin
         secure_q <= 1'b0;
      end
      else if (cmd.wr && cmd.addr == ADDR_SECURE && cmd.wdata[0])
      begin
         secure_q <= 1'b1;
      end
   end
   // ****************************************
   // preload path
   // ****************************************
   // one-cycle strobe, upper byte selects cells, lower byte gives levels
   assign pre_en = (cmd.wr && cmd.addr == ADDR_PRELOAD) ? cmd.wdata[15:8] : '0;
   assign pre_val = cmd.wdata[7:0];
   // ****************************************
   // registered output cells
   // ****************************************
   // one cell per registered output; all share the clear, each takes its own preload strobe bit
   for (genvar g = 0; g < NUM_REGS; g++)
   begin : g_cell
      preload_cell u_cell
      (
         .mclk(mclk),
         .rst(rst),
         .por_busy(por_busy),
         .next_d(next_vec[g]),
         .pre_en(pre_en[g]),
         .pre_val(pre_val[g]),
         .polarity(pol_q[g]),
         .oe(oe_q[g]),
         .q_true(q_vec[g]),
         .pin_o(out_pin_o[g]),
         .pin_oe(out_pin_oe[g])
      );
   end
   // ****************************************
   // read port
   // ****************************************
   // data stand one cycle after the strobe and only then
   // clearing outside the read cycle keeps stale data off the port
   always_ff @(posedge mclk)
   begin
      if (rst)
      begin
         rdata_q <= '0;
         refused_q <= 1'b0;
      end
      else if (cmd.rd)
      begin
         refused_q <= 1'b0;
         if (cfg_hit)
         begin
            if (secure_q)
            begin
               rdata_q <= READ_REFUSED;
               refused_q <= 1'b1;
            end
            else
            begin
               rdata_q <= cfg_mem[cmd.addr[CFG_ADDR_W-1:0]];
            end
         end
         else if (sig_hit)
         begin
            rdata_q <= sig_q[cmd.addr[SIG_ADDR_W-1:0]*16 +: 16];
         end
         else if (cmd.addr == ADDR_POL)
         begin
            rdata_q <= {8'h00, pol_q};
         end
         else if (cmd.addr == ADDR_OE)
         begin
            rdata_q <= {8'h00, oe_q};
         end
         else if (cmd.addr == ADDR_STATUS)
         begin
            rdata_q <= '0;
            rdata_q[ST_SECURE] <= secure_q;
            rdata_q[ST_PORST] <= por_busy;
            rdata_q[ST_REFUSED] <= refused_q;
         end
         else
         begin
            // unmapped reads give zero
            rdata_q <= '0;
         end
      end
      else
      begin
         rdata_q <= '0;
      end
   end
   assign rdata = rdata_q;
endmodule

// *** design/pld_init_pkg.sv ***
// package: constants, types and timing for the register init and security block
package pld_init_pkg;
   // ****************************************
   // sizes
   // ****************************************
   localparam int unsigned NUM_REGS = 8;         // registered outputs
   localparam int unsigned NUM_INPUTS = 8;       // array input pins
   localparam int unsigned SIG_BITS = 64;        // user signature width
   localparam int unsigned CFG_WORDS = 16;       // configuration words
   localparam int unsigned CFG_ADDR_W = 4;       // configuration word address width
   localparam int unsigned CFG_W = 16;           // configuration word width
   localparam int unsigned SIG_ADDR_W = 2;       // signature word address
   // ****************************************
   // register map of the command port
   // ****************************************
   localparam logic [7:0] ADDR_CFG_BASE = 8'h00;  // 0x00..0x0f: array words
   localparam logic [7:0] ADDR_SIG_BASE = 8'h10;  // 0x10..0x13: signature words
   localparam logic [7:0] ADDR_POL = 8'h20;       // output polarity bits
   localparam logic [7:0] ADDR_OE = 8'h21;        // output enable bits
   localparam logic [7:0] ADDR_SECURE = 8'h22;    // write 1 arms security
   localparam logic [7:0] ADDR_PRELOAD = 8'h23;   // preload: mask hi, value lo
   localparam logic [7:0] ADDR_PROG = 8'h24;      // write 1 starts reprogram; the signature is kept
   localparam logic [7:0] ADDR_STATUS = 8'h25;    // status
   localparam logic [15:0] READ_REFUSED = 16'h0000; // value on refused read
   localparam logic [15:0] RESET_WORD = 16'h0000;   // reset value of words
   // status bit positions
   localparam int unsigned ST_SECURE = 0;
   localparam int unsigned ST_PORST = 1;
   localparam int unsigned ST_REFUSED = 2;
   // ****************************************
   // timing
   // ****************************************
   localparam int unsigned CLK_MHZ = 10;          // mclk rate
   localparam int unsigned TPR_US = 1;            // power-up reset time, max
   localparam int unsigned TPR_CYC = (TPR_US * CLK_MHZ > 0) ? TPR_US * CLK_MHZ : 1;
   localparam logic [3:0] TPR_LAST = 4'(TPR_CYC - 1);
   // ****************************************
   // types
   // ****************************************
   typedef struct packed
   {
      logic [7:0] addr;
      logic [15:0] wdata;
      logic wr;
      logic rd;
   } cmd_t;
   typedef enum {ST_PORST_RUN, ST_RUN} por_state_t;
endpackage

// *** design/preload_cell.sv ***
// file: one registered output cell with power-up clear and preload
`timescale 1ns/100ps
module preload_cell
   import pld_init_pkg::*;
(
   input wire logic mclk,
   input wire logic rst,
   input wire logic por_busy,
   input wire logic next_d,
   input wire logic pre_en,
   input wire logic pre_val,
   input wire logic polarity,
   input wire logic oe,
   output logic q_true,
   output logic pin_o,
   output logic pin_oe
);
   // ****************************************
   // state register
   // ****************************************
   logic q_q;  // true output of the flip-flop
   // next state: preload overrides the array feedback path
   always_ff @(posedge mclk)
   begin
      if (rst || por_busy)
      begin
         q_q <= 1'b0;
      end
      else if (pre_en)
      begin
         q_q <= pre_val;
      end
      else
      begin
         q_q <= next_d;
      end
   end
   assign q_true = q_q;
   assign pin_o = q_q ^ polarity;
   assign pin_oe = oe;
endmodule

// *** bench/pld_init_properties.sv ***
// checker: port-level properties of the register init block
`timescale 1ns/100ps
module pld_init_properties
   import pld_init_pkg::*;
(
   input wire logic mclk,
   input wire logic rst,
   input wire logic [7:0] addr,
   input wire logic [15:0] wdata,
   input wire logic wr,
   input wire logic rd,
   input wire logic [15:0] rdata,
   input wire logic [NUM_INPUTS-1:0] in_pin_i,
   input wire logic [NUM_INPUTS-1:0] in_pin_drv,
   input wire logic [NUM_REGS-1:0] out_pin_o,
   input wire logic [NUM_REGS-1:0] out_pin_oe,
   input wire logic por_done
);
   // ****************************************
   // properties
   // ****************************************
   // $past has no history at the first edge, so that edge is skipped
   logic armed_q = 1'b0;
   always @(posedge mclk)
      armed_q <= 1'b1;
   default clocking cb @(posedge mclk); endclocking
   default disable iff (rst);
   a_por_done_time: assert property ($fell(rst) |-> ##[1:11] por_done)
      else $error("power-up clear too slow");
   a_por_stays_done: assert property (por_done |=> por_done)
      else $error("power-up done dropped");
   // reset itself is watched here, so the default disable is overridden
   a_reset_quiet: assert property (disable iff (1'b0) armed_q && $past(rst) |->
      rdata == 16'h0000 && out_pin_oe == 8'h00 && !por_done)
      else $error("outputs not cleared by reset");
   a_pins_hold_por: assert property (!por_done |-> $stable(out_pin_o) ||
      $past(wr) && ($past(addr) == ADDR_POL || $past(addr) == ADDR_PROG))
      else $error("register moved during power-up");
   a_rdata_idle: assert property (!$past(rd) |-> rdata == 16'h0000)
      else $error("read data outside its cycle");
   a_oe_cause: assert property ($changed(out_pin_oe) |-> $past(wr) &&
      ($past(addr) == ADDR_OE || $past(addr) == ADDR_PROG))
      else $error("enable changed without a write");
   a_oe_value: assert property (wr && addr == ADDR_OE |=>
      out_pin_oe == $past(wdata[7:0]))
      else $error("enable not taken from write");
   a_prog_clears: assert property (wr && addr == ADDR_PROG && wdata[0] |=>
      out_pin_oe == 8'h00)
      else $error("reprogram left enables set");
   cover property (rd && addr == ADDR_SIG_BASE);
   cover property (por_done && wr && addr == ADDR_PRELOAD);
   cover property (wr && addr == ADDR_PROG && wdata[0]);
endmodule

bind pld_register_init pld_init_properties u_props (.mclk(mclk), .rst(rst), .addr(addr),
   .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .in_pin_i(in_pin_i),
   .in_pin_drv(in_pin_drv), .out_pin_o(out_pin_o), .out_pin_oe(out_pin_oe),
   .por_done(por_done));

// *** bench/pin_partner.sv ***
// partner: system-side driver of the array input pins
`timescale 1ns/100ps
module pin_partner
   import pld_init_pkg::*;
(
   input wire logic mclk,
   input wire logic [NUM_INPUTS-1:0] lvl,
   input wire logic [NUM_INPUTS-1:0] drv,
   output logic [NUM_INPUTS-1:0] in_pin_i,
   output logic [NUM_INPUTS-1:0] in_pin_drv
);
   // ****************************************
   // pin wires
   // ****************************************
   logic [NUM_INPUTS-1:0] tog_q = '0; // garbage seen on released wires
   // released wires toggle, so only the pull-up flag can make them one
   // pins move just after the edge
   always @(posedge mclk)
      tog_q <= ~tog_q;
   assign in_pin_i = (lvl & drv) | (tog_q & ~drv);
   assign in_pin_drv = drv;
endmodule

// *** bench/pld_register_init_tb.sv ***
// testbench: power-up, signature, security, preload and pull-up scenarios
`timescale 1ns/100ps
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin fails++; \
   $display("wrong value at %0t: %h expected %h", $time, (a), (b)); end end
module pld_register_init_tb
   import pld_init_pkg::*;
();
   // ****************************************
   // stimulus and wiring
   // ****************************************
   logic mclk = 1'b0, rst = 1'b1, wr = 1'b0, rd = 1'b0;
   logic [7:0] addr = 8'h00, lvl = 8'h00, drv = 8'hff; // all pins driven low
   logic [15:0] wdata = 16'h0000, rdata, rv;
   logic [7:0] out_pin_o, out_pin_oe, in_pin_i, in_pin_drv;
   logic por_done;
   int fails = 0, checks = 0, n;
   always #50 mclk = ~mclk;
   pin_partner u_pins (.mclk(mclk), .lvl(lvl), .drv(drv), .in_pin_i(in_pin_i),
      .in_pin_drv(in_pin_drv));
   pld_register_init dut (.mclk(mclk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr),
      .rd(rd), .rdata(rdata), .in_pin_i(in_pin_i), .in_pin_drv(in_pin_drv),
      .out_pin_o(out_pin_o), .out_pin_oe(out_pin_oe), .por_done(por_done));
   // one write cycle; effect visible when the task returns
   task automatic wr_reg(input logic [7:0] a, input logic [15:0] d);
      @(posedge mclk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge mclk);
      wr <= 1'b0;
      #1;
   endtask
   // one read cycle; data stands only in the following cycle
   task automatic chk_rd(input logic [7:0] a, input logic [15:0] e);
      @(posedge mclk);
      addr <= a;
      rd <= 1'b1;
      @(posedge mclk);
      rd <= 1'b0;
      #1;
      rv = rdata;
      `CHK(rv, e)
   endtask
   task report_and_stop;
      $display("checks %0d fails %0d", checks, fails);
      if (fails == 0 && checks > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   // preload during the clear must be ignored, then done inside the limit
   task automatic t_power_up;
      repeat (16) @(posedge mclk);
      rst <= 1'b0;
      #1;
      wr_reg(ADDR_PRELOAD, 16'hffff);
      `CHK(out_pin_o, 8'h00)
      chk_rd(ADDR_STATUS, 16'h0002);
      // n counts edges since release; the read above ends on edge four
      n = 4;
      // wait for the clear to end
      while (por_done !== 1'b1 && n < 30)
      begin
         @(posedge mclk);
         #1;
         n++;
      end
      `CHK(n <= TPR_CYC, 1'b1)
      `CHK(out_pin_o, 8'h00)
      `CHK(out_pin_oe, 8'h00)
      if (por_done !== 1'b1)
         report_and_stop();
   endtask
   // array hidden once armed, signature always visible, reprogram erases
   task automatic t_security;
      wr_reg(ADDR_CFG_BASE + 8'h05, 16'h5a5a);
      chk_rd(ADDR_CFG_BASE + 8'h05, 16'h5a5a);
      for (int k = 0; k < 4; k++)
         wr_reg(ADDR_SIG_BASE + 8'(k), 16'h0f0f + 16'(k) * 16'h1111);
      wr_reg(ADDR_SECURE, 16'h0001);
      wr_reg(ADDR_SECURE, 16'h0000);
      chk_rd(ADDR_CFG_BASE + 8'h05, READ_REFUSED);
      chk_rd(ADDR_STATUS, 16'h0005);
      for (int k = 0; k < 4; k++)
         chk_rd(ADDR_SIG_BASE + 8'(k), 16'h0f0f + 16'(k) * 16'h1111);
      chk_rd(8'h30, 16'h0000);
      wr_reg(ADDR_PROG, 16'h0001);
      chk_rd(ADDR_STATUS, 16'h0000);
      chk_rd(ADDR_CFG_BASE + 8'h05, RESET_WORD);
      chk_rd(ADDR_SIG_BASE + 8'h03, 16'h4242);
   endtask
   // erased array gives next state zero, so a preload lasts one cycle
   task automatic t_preload;
      wr_reg(ADDR_POL, 16'h000f);
      wr_reg(ADDR_OE, 16'h00ff);
      wr_reg(ADDR_PRELOAD, 16'hffa5);
      `CHK(out_pin_o, 8'haa)
      `CHK(out_pin_oe, 8'hff)
      @(posedge mclk);
      #1;
      `CHK(out_pin_o, 8'h0f)
      wr_reg(ADDR_PRELOAD, 16'h0303);
      `CHK(out_pin_o, 8'h0c)
   endtask
   // word zero copies input zero into register zero
   task automatic t_pullup;
      wr_reg(ADDR_POL, 16'h0000);
      wr_reg(ADDR_CFG_BASE, 16'h0001);
      @(posedge mclk);
      drv <= 8'hfe;
      repeat (5) @(posedge mclk);
      #1;
      `CHK(out_pin_o[0], 1'b1)
      // the released wire toggles, so a cycle later it must still read one
      @(posedge mclk);
      #1;
      `CHK(out_pin_o[0], 1'b1)
      @(posedge mclk);
      drv <= 8'hff;
      repeat (5) @(posedge mclk);
      #1;
      `CHK(out_pin_o[0], 1'b0)
   endtask
   initial
   begin
      t_power_up();
      t_security();
      t_preload();
      t_pullup();
      report_and_stop();
   end
endmodule
